// *** core/frame_cell_oam_shaper.sv ***
/*
 Frame-to-cell interworking path: user cells are buffered and shaped by a
 dual leaky bucket toward the network; network cells are split into F5 OAM
 frames toward the user and data cells toward reassembly.
 Assumes cells arrive whole, inputs synchronous to ref_clk, reassembly and
 frame checksums handled outside.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_cell_oam_shaper
   import shaper_pkg::*;
(
   input wire logic ref_clk, // 20 MHz clock
   input wire logic nrst, // Async reset, active low
   // Traffic contract: increments and tolerance in cell times, burst size in cells
   input wire logic [15:0] pcr_incr, // 1/PCR
   input wire logic [15:0] scr_incr, // 1/SCR
   input wire logic [15:0] mbs, // Max burst size, cells
   input wire logic [15:0] cdvt, // Delay tolerance
   input wire logic oam_enable, // OAM interworking on
   input wire logic [7:0] conn_vpi, // Connection VPI
   input wire logic [15:0] conn_vci, // Connection VCI
   // From user frames toward the network
   input wire logic up_valid, // Cell offered
   output logic up_ready, // Cell taken
   input wire logic [CELL_BITS-1:0] up_cell, // Cell incl. header
   input wire logic up_oam, // Data holds an OAM cell
   input wire logic up_clp, // Submitted loss priority
   // Shaped cells to next ATM layer
   output logic atm_valid, // Cell present
   input wire logic atm_ready, // Cell taken
   output logic [CELL_BITS-1:0] atm_cell, // Cell out
   // Cells from next ATM layer
   input wire logic dn_valid, // Cell offered
   output logic dn_ready, // Cell taken
   input wire logic [CELL_BITS-1:0] dn_cell, // Cell in
   // OAM frames toward the user
   output logic frm_valid, // Frame present
   input wire logic frm_ready, // Frame taken
   output logic [CELL_BITS-1:0] frm_data, // Frame user data
   output logic frm_oam, // OAM indicator
   output logic frm_clp, // Cell loss priority
   output logic frm_efci, // Congestion indication
   // Data cells toward reassembly
   output logic ra_valid, // Cell present
   input wire logic ra_ready, // Cell taken
   output logic [CELL_BITS-1:0] ra_cell, // Cell out
   // Status
   output logic [23:0] sustained_clumping_limit, // Derived limit
   output logic [23:0] max_burst_period, // Burst start spacing
   output logic [15:0] up_drop_count, // User cells dropped
   output logic [15:0] dn_drop_count // Network cells dropped
);
   localparam int FW = CELL_BITS + 1;

   // Cell-time divider
   logic [7:0] tick_cnt_q, tick_cnt_d;
   logic tick;

   always_comb begin
      tick = tick_cnt_q == TICK_CNT_MAX;
      tick_cnt_d = tick ? TICK_CNT_RST : tick_cnt_q + 8'h01;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt_q <= TICK_CNT_RST;
      end else begin
         tick_cnt_q <= tick_cnt_d;
      end
   end

   // Limits derived from the contract
   logic [23:0] ls_q, ls_d, ts_q, ts_d;
   logic [16:0] rate_gap;
   logic [32:0] ls_full;

   always_comb begin
      rate_gap = (scr_incr > pcr_incr) ? {1'b0, scr_incr} - {1'b0, pcr_incr} : 17'h00000;
      // Widen before the product so large contracts saturate instead of wrapping
      ls_full = ({17'h00000, (mbs == CNT_RST ? 16'h0000 : mbs - 16'h0001)} * {16'h0000, rate_gap})
                + {17'h00000, cdvt};
      ls_d = (ls_full > 33'h000FFFFFF) ? 24'hFFFFFF : ls_full[23:0];
      ts_d = (ls_q > 24'hFFFFFF - {8'h00, scr_incr}) ? 24'hFFFFFF : ls_q + {8'h00, scr_incr};
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ls_q <= LEVEL_RST;
         ts_q <= LEVEL_RST;
      end else begin
         ls_q <= ls_d;
         ts_q <= ts_d;
      end
   end

   assign sustained_clumping_limit = ls_q;
   assign max_burst_period = ts_q;

   // User-to-network: rebuild header, drop unsupported OAM
   logic up_keep;
   logic [CELL_BITS-1:0] up_built;
   logic up_push_ready;
   logic [15:0] up_drop_q, up_drop_d;

   always_comb begin
      up_built = up_cell;
      up_built[CELL_BITS-1:CELL_BITS-HDR_BITS] = '0;
      up_built[VPI_HI:VPI_LO] = conn_vpi;
      up_built[VCI_HI:VCI_LO] = conn_vci;
      up_built[CLP_POS] = up_clp;
      if (up_oam) begin
         up_keep = oam_enable && is_f5_oam(up_cell[PTI_HI:PTI_LO])
                   && up_cell[CELL_BITS-1:PTI_HI+1] == '0;
         up_built[PTI_HI:PTI_LO] = up_cell[PTI_HI:PTI_LO];
      end else begin
         up_keep = 1'b1;
         up_built[PTI_HI:PTI_LO] = PTI_USER_DATA;
      end
      up_drop_d = (up_valid && up_push_ready && !up_keep) ? up_drop_q + 16'h0001 : up_drop_q;
   end

   logic fifo_out_valid, fifo_pop;
   logic [FW-1:0] fifo_out;

   cell_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .in_valid(up_valid && up_keep),
      .in_ready(up_push_ready),
      .in_data({up_oam, up_built}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out)
   );

   assign up_ready = up_push_ready;

   // Shaper toward the network
   logic peak_ok, sus_ok, sus_empty, burst_ok;
   logic [15:0] burst_q, burst_d;
   logic atm_valid_q, atm_valid_d;
   logic [CELL_BITS-1:0] atm_cell_q, atm_cell_d;

   gcra_bucket u_peak (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .tick(tick),
      .emit(fifo_pop),
      .incr(pcr_incr),
      .limit({8'h00, cdvt}),
      .ok(peak_ok),
      .empty()
   );

   gcra_bucket u_sus (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .tick(tick),
      .emit(fifo_pop),
      .incr(scr_incr),
      .limit(ls_q),
      .ok(sus_ok),
      .empty(sus_empty)
   );

   always_comb begin
      burst_ok = (mbs == CNT_RST) || (burst_q < mbs);
      // release only on a tick with both buckets within limit, burst room left and the output free
      fifo_pop = tick && fifo_out_valid && peak_ok && sus_ok && burst_ok
                 && (!atm_valid_q || atm_ready);
      if (fifo_pop) begin
         burst_d = burst_q + 16'h0001;
      end else if (sus_empty) begin
         burst_d = CNT_RST;
      end else begin
         burst_d = burst_q;
      end
      atm_valid_d = atm_valid_q && !atm_ready;
      atm_cell_d = atm_cell_q;
      if (fifo_pop) begin
         atm_valid_d = 1'b1;
         atm_cell_d = fifo_out[CELL_BITS-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         burst_q <= CNT_RST;
         atm_valid_q <= 1'b0;
         atm_cell_q <= '0;
         up_drop_q <= CNT_RST;
      end else begin
         burst_q <= burst_d;
         atm_valid_q <= atm_valid_d;
         atm_cell_q <= atm_cell_d;
         up_drop_q <= up_drop_d;
      end
   end

   assign atm_valid = atm_valid_q;
   assign atm_cell = atm_cell_q;
   assign up_drop_count = up_drop_q;

   // Network-to-user: split OAM from data cells
   logic [2:0] dn_pti;
   logic dn_take, dn_is_oam, dn_frame_it, dn_f4;
   logic dn_ready_q, dn_ready_d;
   logic frm_valid_q, frm_valid_d, frm_clp_q, frm_clp_d;
   logic [CELL_BITS-1:0] frm_data_q, frm_data_d, ra_cell_q, ra_cell_d;
   logic ra_valid_q, ra_valid_d;
   logic [15:0] dn_drop_q, dn_drop_d;

   always_comb begin
      dn_pti = dn_cell[PTI_HI:PTI_LO];
      dn_take = dn_valid && dn_ready_q;
      dn_is_oam = dn_pti[2];
      dn_f4 = dn_cell[VCI_HI:VCI_LO] == VCI_F4_SEG || dn_cell[VCI_HI:VCI_LO] == VCI_F4_E2E;
      dn_frame_it = dn_is_oam && oam_enable && is_f5_oam(dn_pti) && !dn_f4;
      frm_valid_d = frm_valid_q && !frm_ready;
      frm_data_d = frm_data_q;
      frm_clp_d = frm_clp_q;
      ra_valid_d = ra_valid_q && !ra_ready;
      ra_cell_d = ra_cell_q;
      dn_drop_d = dn_drop_q;
      if (dn_take) begin
         if (dn_frame_it) begin
            // framed at once; taken only while the reassembly outlet is also free
            frm_valid_d = 1'b1;
            frm_data_d = dn_cell;
            frm_clp_d = dn_cell[CLP_POS];
         end else if (!dn_is_oam && !dn_f4) begin
            ra_valid_d = 1'b1;
            ra_cell_d = dn_cell;
         end else begin
            dn_drop_d = dn_drop_q + 16'h0001;
         end
      end
      // Take a new cell only when both outlets will be free, which
      // trades half throughput for a registered ready
      dn_ready_d = !frm_valid_d && !ra_valid_d && !dn_take;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dn_ready_q <= 1'b0;
         frm_valid_q <= 1'b0;
         frm_data_q <= '0;
         frm_clp_q <= 1'b0;
         ra_valid_q <= 1'b0;
         ra_cell_q <= '0;
         dn_drop_q <= CNT_RST;
      end else begin
         dn_ready_q <= dn_ready_d;
         frm_valid_q <= frm_valid_d;
         frm_data_q <= frm_data_d;
         frm_clp_q <= frm_clp_d;
         ra_valid_q <= ra_valid_d;
         ra_cell_q <= ra_cell_d;
         dn_drop_q <= dn_drop_d;
      end
   end

   assign dn_ready = dn_ready_q;
   assign frm_valid = frm_valid_q;
   assign frm_data = frm_data_q;
   // only OAM frames leave this port
   assign frm_oam = frm_valid_q;
   assign frm_clp = frm_clp_q;
   assign frm_efci = 1'b0;
   assign ra_valid = ra_valid_q;
   assign ra_cell = ra_cell_q;
   assign dn_drop_count = dn_drop_q;
endmodule : frame_cell_oam_shaper
`default_nettype wire

// *** core/shaper_pkg.sv ***
/*
 Constants shared by the frame-to-cell interworking block: cell layout,
 header field positions, payload type codes, cell-time divider, reset values.
 Assumes a single 20 MHz clock and cells carried whole as 424-bit words.
*/
package shaper_pkg;
   localparam int CELL_BITS = 424;
   localparam int HDR_BITS = 40;
   localparam int FIFO_DEPTH = 8;
   // Header bit positions within the 424-bit cell (octet 1 in the top bits)
   localparam int VPI_HI = 419;
   localparam int VPI_LO = 412;
   localparam int VCI_HI = 411;
   localparam int VCI_LO = 396;
   // Octet 4 carries PTI in its bits 3 to 1 and CLP in bit 0; octet 5 is the HEC
   localparam int PTI_HI = 395;
   localparam int PTI_LO = 393;
   localparam int CLP_POS = 392;
   localparam logic [2:0] PTI_F5_SEG = 3'h4;
   localparam logic [2:0] PTI_F5_E2E = 3'h5;
   localparam logic [2:0] PTI_USER_DATA = 3'h0;
   localparam logic [15:0] VCI_F4_SEG = 16'h0003;
   localparam logic [15:0] VCI_F4_E2E = 16'h0004;
   // Cell time in ns; shaping counters count in these units
   localparam int CLK_PERIOD_NS = 50;
   localparam int CELL_TIME_NS = 2800;
   localparam int CELL_CYCLES = CELL_TIME_NS / CLK_PERIOD_NS;
   localparam logic [7:0] TICK_CNT_MAX = 8'(CELL_CYCLES - 1);
   localparam logic [7:0] TICK_CNT_RST = 8'h00;
   localparam logic [23:0] LEVEL_RST = 24'h000000;
   localparam logic [15:0] CNT_RST = 16'h0000;

   function automatic logic is_f5_oam(input logic [2:0] pti);
      is_f5_oam = (pti == PTI_F5_SEG) || (pti == PTI_F5_E2E);
   endfunction : is_f5_oam
endpackage : shaper_pkg

// *** core/cell_fifo.sv ***
/*
 Synchronous FIFO with valid/ready on both sides; width and depth are parameters.
 Assumes one clock; depth is a power of two; ready and valid come from flip-flops.
*/
`timescale 1ns/1ps
`default_nettype none
module cell_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk, // Clock
   input wire logic nrst, // Async reset, active low
   input wire logic in_valid, // Write request
   output logic in_ready, // Space available
   input wire logic [WIDTH-1:0] in_data, // Write word
   output logic out_valid, // Word available
   input wire logic out_ready, // Read accept
   output logic [WIDTH-1:0] out_data // Head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic full_q, full_d, empty_q, empty_d;
   logic push, pop;

   always_comb begin
      push = in_valid && !full_q;
      pop = out_ready && !empty_q;
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      full_d = cnt_d == (AW+1)'(DEPTH);
      empty_d = cnt_d == '0;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         full_q <= 1'b0;
         empty_q <= 1'b1;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         full_q <= full_d;
         empty_q <= empty_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   assign in_ready = !full_q;
   assign out_valid = !empty_q;
   assign out_data = mem[rd_q];
endmodule : cell_fifo
`default_nettype wire

// *** core/gcra_bucket.sv ***
/*
 One continuous-state leaky bucket in cell-time units. The level drains by one
 per cell tick and rises by the increment on each emission; a cell conforms
 while the level is within the limit. Assumes tick is a one-cycle enable.
*/
`timescale 1ns/1ps
`default_nettype none
module gcra_bucket
   import shaper_pkg::*;
(
   input wire logic ref_clk, // Clock
   input wire logic nrst, // Async reset, active low
   input wire logic tick, // One cell time elapsed
   input wire logic emit, // Cell sent this cycle
   input wire logic [15:0] incr, // Increment, cell times per cell
   input wire logic [23:0] limit, // Clumping limit, cell times
   output logic ok, // Next cell would conform
   output logic empty // Bucket fully drained
);
   logic [23:0] level_q, level_d;
   logic [24:0] sum;

   always_comb begin
      sum = {1'b0, level_q} + (emit ? {9'h000, incr} : 25'h0000000);
      if (tick && sum != 25'h0000000) begin
         sum = sum - 25'h0000001;
      end
      // Saturate rather than wrap, so a huge increment cannot reopen the gate
      level_d = sum[24] ? 24'hFFFFFF : sum[23:0];
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         level_q <= LEVEL_RST;
      end else begin
         level_q <= level_d;
      end
   end

   assign ok = level_q <= limit;
   assign empty = level_q == LEVEL_RST;
endmodule : gcra_bucket
`default_nettype wire

// *** test/frame_cell_oam_shaper_props.sv ***
/*
 Port checker for frame_cell_oam_shaper.
 Assumes a bind onto the top module and the single ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_cell_oam_shaper_props
   import shaper_pkg::*;
(
   input wire logic ref_clk, // Clock
   input wire logic nrst, // Reset
   input wire logic oam_enable, // OAM on
   input wire logic atm_valid, // Cell out
   input wire logic atm_ready, // Taken
   input wire logic [CELL_BITS-1:0] atm_cell, // Cell
   input wire logic dn_valid, // Cell in
   input wire logic dn_ready, // Taken
   input wire logic [CELL_BITS-1:0] dn_cell, // Cell
   input wire logic frm_valid, // Frame out
   input wire logic [CELL_BITS-1:0] frm_data, // Data
   input wire logic frm_oam, // OAM flag
   input wire logic frm_clp, // Priority
   input wire logic frm_efci, // Congestion
   input wire logic ra_valid, // Data out
   input wire logic [CELL_BITS-1:0] ra_cell // Cell
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic take, f5, f4, held_q, held_d;
   logic [15:0] gap_q, gap_d;
   // PTI sits in header octet 4, bits 3:1
   assign take = dn_valid && dn_ready;
   assign f5 = dn_cell[395:393] inside {3'h4, 3'h5};
   assign f4 = dn_cell[411:396] inside {VCI_F4_SEG, VCI_F4_E2E};
   always_comb begin
      held_d = atm_valid && !atm_ready;
      gap_d = (atm_valid && !held_q) ? 16'h0001 : gap_q + 16'(gap_q != 16'hFFFF);
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         held_q <= 1'b0;
         gap_q <= 16'hFFFF;
      end else begin
         held_q <= held_d;
         gap_q <= gap_d;
      end
   end
   a_oam_flag_match: assert property (frm_oam == frm_valid)
      else $error("OAM flag differs from frame valid");
   a_efci_held_zero: assert property (frm_efci == 1'b0)
      else $error("frame congestion bit set");
   a_frame_f5_only: assert property (frm_valid |-> frm_data[395:393] inside {3'h4, 3'h5})
      else $error("frame holds a non F5 cell");
   a_frame_clp_copy: assert property (frm_valid |-> frm_clp == frm_data[392])
      else $error("frame priority differs from cell");
   a_oam_framed_next: assert property (
      take && oam_enable && f5 && !f4 |=> frm_valid && frm_data == $past(dn_cell))
      else $error("OAM cell not framed next cycle");
   a_oam_off_drop: assert property (take && !oam_enable |=> !frm_valid)
      else $error("OAM framed while disabled");
   a_data_to_reasm: assert property (
      take && !dn_cell[395] && !f4 |=> ra_valid && !frm_valid && ra_cell == $past(dn_cell))
      else $error("data cell not passed to reassembly");
   a_atm_cell_held: assert property (atm_valid && !atm_ready |=> atm_valid && $stable(atm_cell))
      else $error("network cell lost before taken");
   a_cell_time_gap: assert property (atm_valid && !held_q |-> gap_q >= 16'(CELL_CYCLES))
      else $error("network cells closer than a cell time");
endmodule : frame_cell_oam_shaper_props
`default_nettype wire

// *** test/atm_layer_model.sv ***
/*
 Next ATM layer: takes shaped cells, none while stall is high, and
 scores each new cell against peak, sustained and burst limits.
 Assumes cells only appear on cell-time ticks of ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module atm_layer_model
   import shaper_pkg::*;
(
   input wire logic ref_clk, // Clock
   input wire logic nrst, // Reset
   input wire logic stall, // Stops taking
   input wire logic [15:0] pcr_incr, // 1/PCR
   input wire logic [15:0] scr_incr, // 1/SCR
   input wire logic [15:0] mbs, // Burst cap
   input wire logic [15:0] cdvt, // Tolerance
   input wire logic atm_valid, // Cell present
   output var logic atm_ready, // Taken
   input wire logic [CELL_BITS-1:0] atm_cell, // Cell
   output var logic [7:0] got_count, // Cells taken
   output var logic [7:0] bad_count, // Breaches
   output var logic [CELL_BITS-1:0] last_cell // Last cell
);
   longint cyc, tat_p, tat_s, ls, run, last_t;
   logic held;
   initial atm_ready = 1'b0;
   always @(posedge ref_clk) #1 atm_ready = !stall;
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         {cyc, tat_p, tat_s, run, last_t} = '0;
         held = 1'b0;
         got_count = 8'h00;
         bad_count = 8'h00;
         last_cell = '0;
      end else begin
         cyc++;
         // Timing judged where a cell first shows, since a stall only delays taking
         if (atm_valid && !held) begin
            ls = (mbs - 1) * (scr_incr - pcr_incr) + cdvt;
            if (cyc + cdvt * CELL_CYCLES < tat_p) bad_count++;
            tat_p = (cyc > tat_p ? cyc : tat_p) + pcr_incr * CELL_CYCLES;
            if (cyc + ls * CELL_CYCLES < tat_s) bad_count++;
            tat_s = (cyc > tat_s ? cyc : tat_s) + scr_incr * CELL_CYCLES;
            run = (cyc - last_t <= pcr_incr * CELL_CYCLES) ? run + 1 : 1;
            if (mbs != 0 && run > mbs) bad_count++;
            last_t = cyc;
         end
         if (atm_valid && atm_ready) begin
            got_count++;
            last_cell = atm_cell;
         end
         held = atm_valid && !atm_ready;
      end
   end
endmodule : atm_layer_model
`default_nettype wire

// *** test/tb_frame_cell_oam_shaper.sv ***
/*
 Testbench: contract limits, shaped user cells, OAM cells both ways.
 Assumes the checker and the next-layer model beside it in test/.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_frame_cell_oam_shaper
   import shaper_pkg::*;
;
   logic ref_clk = 1'b0, nrst = 1'b0, oam_enable = 1'b1, stall = 1'b1;
   logic up_valid = 1'b0, up_oam = 1'b0, up_clp = 1'b0, dn_valid = 1'b0, frm_ready = 1'b1, ra_ready = 1'b1;
   logic [7:0] conn_vpi = 8'h5A;
   logic [15:0] conn_vci = 16'h1234, pcr_incr = 16'h0002, scr_incr = 16'h0004, mbs = 16'h0003, cdvt = 16'h0000;
   logic [CELL_BITS-1:0] up_cell = '0, dn_cell = '0, c;
   logic up_ready, atm_valid, atm_ready, dn_ready, frm_valid, frm_oam, frm_clp, frm_efci, ra_valid;
   logic [CELL_BITS-1:0] atm_cell, frm_data, ra_cell, last_cell;
   logic [23:0] sustained_clumping_limit, max_burst_period;
   logic [15:0] up_drop_count, dn_drop_count;
   logic [7:0] got_count, bad_count;
   int fails = 0, check_count = 0;
   frame_cell_oam_shaper u_dut (.*);
   atm_layer_model u_model (.*);
   always #25 ref_clk = ~ref_clk;
   // Standard header: PTI in octet 4 bits 3:1, CLP in bit 0, HEC left zero
   function automatic logic [CELL_BITS-1:0] mk(input logic [7:0] vp, input logic [15:0] vc,
         input logic [2:0] pt, input logic cl, input logic [7:0] pl);
      mk = {4'h0, vp, vc, pt, cl, 8'h00, {48{pl}}};
   endfunction : mk
   task automatic cmp_cell(input logic [CELL_BITS-1:0] g, input logic [CELL_BITS-1:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("ERROR at %0t got %h expected %h", $time, g, e);
      end
   endtask : cmp_cell
   task automatic cmp_val(input logic [23:0] g, input logic [23:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("ERROR at %0t got %h expected %h", $time, g, e);
      end
   endtask : cmp_val
   task automatic put_up(input logic [CELL_BITS-1:0] d, input logic o, input logic l);
      up_cell = d;
      up_oam = o;
      up_clp = l;
      up_valid = 1'b1;
      do @(posedge ref_clk); while (up_ready !== 1'b1);
      #1 up_valid = 1'b0;
      @(posedge ref_clk);
      #1;
   endtask : put_up
   task automatic put_dn(input logic [CELL_BITS-1:0] d);
      dn_cell = d;
      dn_valid = 1'b1;
      do @(posedge ref_clk); while (dn_ready !== 1'b1);
      #1 dn_valid = 1'b0;
   endtask : put_dn
   task automatic wait_got(input int n);
      for (int k = 0; k < 3000 && got_count !== 8'(n); k++) @(posedge ref_clk);
      #1;
   endtask : wait_got
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   initial begin
      int i;
      repeat (8) @(posedge ref_clk);
      #1 nrst = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      cmp_val(sustained_clumping_limit, 24'h000004);
      cmp_val(max_burst_period, 24'h000008);
      // Fill the buffer while the next layer stalls, then drain it
      // user-side shaping is off here, so only the block's shaper keeps the rate
      for (i = 0; i < 8; i++) put_up(mk(8'h00, 16'h0000, 3'h0, 1'b0, 8'(i)), 1'b0, i[0]);
      cmp_val(up_ready, 24'h000000);
      repeat (300) @(posedge ref_clk);
      #1 stall = 1'b0;
      for (i = 0; i < 8; i++) begin
         wait_got(i + 1);
         cmp_cell(last_cell, mk(8'h5A, 16'h1234, 3'h0, i[0], 8'(i)));
      end
      $display("shaping test done");
      for (i = 0; i < 5; i++) begin
         oam_enable = (i != 4);
         put_up(mk(i == 3 ? 8'h01 : 8'h00, 16'h0000, i == 1 ? 3'h5 : i == 2 ? 3'h6 : 3'h4, 1'b0, 8'hA0), 1'b1, i[0]);
         if (i < 2) wait_got(9 + i);
         if (i < 2) cmp_cell(last_cell, mk(8'h5A, 16'h1234, i[0] ? 3'h5 : 3'h4, i[0], 8'hA0));
      end
      oam_enable = 1'b1;
      cmp_val(up_drop_count, 24'h000003);
      cmp_val(bad_count, 24'h000000);
      $display("upstream OAM test done");
      for (i = 0; i < 6; i++) begin
         oam_enable = (i != 5);
         c = mk(8'h07, i == 3 ? 16'h0003 : 16'h0040, i == 0 ? 3'h0 : i == 2 ? 3'h5 : i == 4 ? 3'h6 : 3'h4, i[0], 8'h3C);
         put_dn(c);
         cmp_val({frm_valid, frm_oam, frm_efci, ra_valid, frm_valid & frm_clp},
            i == 0 ? 24'h02 : i == 1 ? 24'h19 : i == 2 ? 24'h18 : 24'h00);
         if (i < 3) cmp_cell(i == 0 ? ra_cell : frm_data, c);
         @(posedge ref_clk);
         #1;
      end
      oam_enable = 1'b1;
      cmp_val(dn_drop_count, 24'h000003);
      $display("downstream OAM test done");
      pcr_incr = 16'h0001;
      scr_incr = 16'h0003;
      mbs = 16'h0005;
      cdvt = 16'h0002;
      repeat (3) @(posedge ref_clk);
      #1;
      cmp_val(sustained_clumping_limit, 24'h00000A);
      cmp_val(max_burst_period, 24'h00000D);
      $display("contract change test done");
      conclude();
   end
   initial begin
      #(20000 * 50);
      fails++;
      conclude();
   end
endmodule : tb_frame_cell_oam_shaper
bind frame_cell_oam_shaper frame_cell_oam_shaper_props u_props (.*);
`default_nettype wire
